// [hw/bmd_pkg.sv]
`default_nettype none
package bmd_pkg;
	// ****************************************
	// phases and decoded operations
	// ****************************************
	typedef enum logic [3:0] {
		PH_Q1 = 4'h1,
		PH_Q2 = 4'h2,
		PH_Q3 = 4'h4,
		PH_Q4 = 4'h8
	} bmd_phase_t;

	typedef enum logic [3:0] {
		OP_NONE = 4'h1,
		OP_MOVB = 4'h2,
		OP_FF1  = 4'h4,
		OP_FF2  = 4'h8
	} bmd_op_t;

	// ****************************************
	// encodings and addressing
	// ****************************************
	localparam logic [5:0]  OPC_MOVB       = 6'h14;
	localparam logic [3:0]  OPC_FF1        = 4'hC;
	localparam logic [3:0]  OPC_FF2        = 4'hF;
	localparam int          BIT_DEST       = 9;
	localparam int          BIT_BANK       = 8;
	localparam int          ADDR_W         = 12;
	localparam int          BANK_W         = 4;
	localparam int          STATUS_W       = 5;
	localparam int          ST_Z           = 2;
	localparam int          ST_N           = 4;
	localparam logic [7:0]  ILO_MAX        = 8'h5F;
	localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
	localparam logic [3:0]  ACCESS_LO_PAGE = 4'h0;
	localparam logic [3:0]  ACCESS_HI_PAGE = 4'hF;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_BANK       = 8'h04;
	localparam logic [7:0]  REG_ACC        = 8'h08;
	localparam logic [7:0]  REG_STATUS     = 8'h0C;
	localparam logic [7:0]  REG_STATE      = 8'h10;
	localparam int          CTRL_EXT       = 0;
	localparam logic [7:0]  RST_ACC        = 8'h00;
	localparam logic [3:0]  RST_BANK       = 4'h0;
	localparam logic [4:0]  RST_STATUS     = 5'h00;
endpackage
`default_nettype wire

// [hw/bmd_core_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface bmd_core_if;
	import bmd_pkg::*;
	bmd_phase_t  phase;
	logic [15:0] word;
	logic        ff_pend;
	bmd_op_t     op;
	logic        dest_f;
	logic        bank_use;
	logic [7:0]  f8;
	logic [11:0] f12;

	modport seq  (output phase);
	modport dec  (input word, ff_pend, output op, dest_f, bank_use, f8, f12);
	modport core (input phase, op, dest_f, bank_use, f8, f12, output word, ff_pend);
endinterface // bmd_core_if
`default_nettype wire

// [hw/bmd_phase.sv]
`timescale 1ns/1ps
`default_nettype none
module bmd_phase import bmd_pkg::*; (
	input  wire logic clk_in,  // core clock
	input  wire logic rstn_in, // sync reset, low
	bmd_core_if.seq   bus      // phase out
);
	typedef struct packed {
		bmd_phase_t ph;
	} bmd_ph_st_t;

	bmd_ph_st_t st;
	bmd_ph_st_t next_st;

	always_comb begin
		next_st = st;
		case (st.ph)
			PH_Q1: next_st.ph = PH_Q2;
			PH_Q2: next_st.ph = PH_Q3;
			PH_Q3: next_st.ph = PH_Q4;
			PH_Q4: next_st.ph = PH_Q1; // [RULE6]
			default: next_st.ph = PH_Q1;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			st <= '{ph: PH_Q1};
		end else begin
			st <= next_st;
		end
	end

	assign bus.phase = st.ph;
endmodule // bmd_phase
`default_nettype wire

// [hw/bmd_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module bmd_decode import bmd_pkg::*; (
	bmd_core_if.dec bus // word in, fields out
);
	always_comb begin
		bus.dest_f   = bus.word[BIT_DEST];
		bus.bank_use = bus.word[BIT_BANK];
		bus.f8       = bus.word[7:0];
		bus.f12      = bus.word[11:0];
		// a lone second word decodes as no-op, which gives the skip its extra cycle
		if (bus.ff_pend) begin
			bus.op = OP_FF2; // [RULE7]
		end else if (bus.word[15:10] == OPC_MOVB) begin
			bus.op = OP_MOVB; // [RULE1]
		end else if (bus.word[15:12] == OPC_FF1) begin
			bus.op = OP_FF1; // [RULE7]
		end else begin
			bus.op = OP_NONE; // [RULE12]
		end
	end
endmodule // bmd_decode
`default_nettype wire

// [hw/bmd_top.sv]
// Notes on behaviour
// [RULE1] single-byte move: 010100, dest, bank, address
// [RULE2] dest 0 to accumulator, 1 to register
// [RULE3] bank 0 access bank, 1 bank select
// [RULE4] access, extended, address<=95 gives indexed mode
// [RULE5] moved byte updates only negative, zero flags
// [RULE6] one word; decode, read, process, write
// [RULE7] two words: 1100 source, 1111 destination
// [RULE8] full 12-bit addresses, no bank selection
// [RULE9] accumulator usable as source or destination
// [RULE10] software never targets PC low or stack
// [RULE11] second cycle: no read, write in phase four
// [RULE12] file-to-file move keeps flags, two cycles
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bmd_top import bmd_pkg::*; #(
	parameter logic [11:0] ACC_DATA_ADDR = 12'hFE8 // data-space address of accumulator
) (
	input  wire logic        SYS_CLK_IN,     // core clock
	input  wire logic        RSTN_IN,        // sync reset, low
	input  wire logic [15:0] INSTR_IN,       // program word, sampled in phase one
	input  wire logic        SKIP_IN,        // squash word sampled in phase one
	output logic             INSTR_TAKE_OUT, // phase one, word taken
	output logic [11:0]      DMEM_ADDR_OUT,  // data address
	output logic             DMEM_RD_OUT,    // read strobe, phase two
	input  wire logic [7:0]  DMEM_RDATA_IN,  // read data, end of phase two
	output logic             DMEM_WR_OUT,    // write strobe, phase four
	output logic [7:0]       DMEM_WDATA_OUT, // write data
	output logic             DMEM_ILO_OUT,   // address is indexed offset
	output logic [7:0]       ACC_OUT,        // accumulator
	output logic [4:0]       STATUS_OUT,     // status flags
	input  wire logic        PSEL,           // apb select
	input  wire logic        PENABLE,        // apb enable
	input  wire logic        PWRITE,         // apb direction
	input  wire logic [7:0]  PADDR,          // apb byte address
	input  wire logic [31:0] PWDATA,         // apb write data
	output logic [31:0]      PRDATA,         // apb read data
	output logic             PREADY,         // apb ready
	output logic             PSLVERR         // apb error
);
	// ****************************************
	// elaboration checks
	// ****************************************
	if (ADDR_W != BANK_W + 8) begin : g_chk
		$error("bank and file address must span the data space");
	end

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic               ext_en;
		logic [BANK_W-1:0]  bank_sel;
		logic [7:0]         acc;
		logic [STATUS_W-1:0] status;
		bmd_op_t            op;
		logic               dest_f;
		logic               ff_pend;
		logic [7:0]         data;
		logic               rd;
		logic               wr;
		logic               ilo;
		logic [ADDR_W-1:0]  addr;
		logic [31:0]        prdata;
	} bmd_top_st_t;

	bmd_top_st_t st;
	bmd_top_st_t next_st;
	bmd_core_if  cif ();

	bmd_phase u_phase (
		.clk_in  (SYS_CLK_IN),
		.rstn_in (RSTN_IN),
		.bus     (cif.seq)
	);

	bmd_decode u_decode (
		.bus (cif.dec)
	);

	assign cif.word    = INSTR_IN;
	assign cif.ff_pend = st.ff_pend;

	// ****************************************
	// bus decode
	// ****************************************
	logic        apb_wr;
	logic        mapped;
	logic [31:0] rd_mux;
	logic        ilo_hit;
	logic [11:0] movb_addr;

	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		case (PADDR)
			REG_CTRL:   rd_mux[CTRL_EXT] = st.ext_en;
			REG_BANK:   rd_mux[BANK_W-1:0] = st.bank_sel;
			REG_ACC:    rd_mux[7:0] = st.acc;
			REG_STATUS: rd_mux[STATUS_W-1:0] = st.status;
			REG_STATE:  rd_mux[8:0] = {st.ff_pend, st.op, cif.phase};
			default:    mapped = 1'b0;
		endcase
		// qualified only after the decode above has settled
		apb_wr = PSEL && PENABLE && PWRITE && mapped;
	end

	// ****************************************
	// address formation
	// ****************************************
	always_comb begin
		ilo_hit = !cif.bank_use && st.ext_en && (cif.f8 <= ILO_MAX); // [RULE4]
		if (cif.bank_use) begin
			movb_addr = {st.bank_sel, cif.f8}; // [RULE3]
		end else if (ilo_hit) begin
			// offset arithmetic lives outside; the raw literal is passed on
			movb_addr = {ACCESS_LO_PAGE, cif.f8}; // [RULE4]
		end else if (cif.f8 < ACCESS_SPLIT) begin
			movb_addr = {ACCESS_LO_PAGE, cif.f8}; // [RULE3]
		end else begin
			movb_addr = {ACCESS_HI_PAGE, cif.f8}; // [RULE3]
		end
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_st    = st;
		next_st.rd = 1'b0;
		next_st.wr = 1'b0;
		if (PSEL && !PENABLE) begin
			next_st.prdata = rd_mux;
		end
		if (apb_wr) begin
			case (PADDR)
				REG_CTRL:   next_st.ext_en = PWDATA[CTRL_EXT];
				REG_BANK:   next_st.bank_sel = PWDATA[BANK_W-1:0];
				REG_ACC:    next_st.acc = PWDATA[7:0];
				REG_STATUS: next_st.status = PWDATA[STATUS_W-1:0];
				default:    ;
			endcase
		end
		// core updates land after bus writes so execution wins a collision
		case (cif.phase)
			PH_Q1: begin
				next_st.op      = SKIP_IN ? OP_NONE : cif.op;
				next_st.dest_f  = cif.dest_f;
				next_st.ff_pend = 1'b0;
				next_st.ilo     = 1'b0;
				if (!SKIP_IN) begin
					case (cif.op)
						OP_MOVB: begin
							next_st.addr = movb_addr; // [RULE1]
							next_st.ilo  = ilo_hit; // [RULE4]
							next_st.rd   = ilo_hit || (movb_addr != ACC_DATA_ADDR);
						end
						OP_FF1: begin
							next_st.ff_pend = 1'b1; // [RULE7]
							next_st.addr    = cif.f12; // [RULE8]
							next_st.rd      = (cif.f12 != ACC_DATA_ADDR); // [RULE9]
						end
						OP_FF2: begin
							next_st.addr = cif.f12; // [RULE8]
						end
						default: ;
					endcase
				end
			end
			PH_Q2: begin
				if (st.op == OP_MOVB || st.op == OP_FF1) begin
					next_st.data = st.rd ? DMEM_RDATA_IN : st.acc; // [RULE9]
				end
			end
			PH_Q3: begin
				if (st.op == OP_MOVB && st.dest_f) begin
					next_st.wr = st.ilo || (st.addr != ACC_DATA_ADDR); // [RULE2]
				end
				if (st.op == OP_FF2) begin
					next_st.wr = (st.addr != ACC_DATA_ADDR); // [RULE11]
				end
			end
			PH_Q4: begin
				if (st.op == OP_MOVB) begin
					if (!st.dest_f || (!st.ilo && st.addr == ACC_DATA_ADDR)) begin
						next_st.acc = st.data; // [RULE2]
					end
					next_st.status[ST_N] = st.data[7]; // [RULE5]
					next_st.status[ST_Z] = (st.data == 8'h00); // [RULE5]
				end
				if (st.op == OP_FF2 && st.addr == ACC_DATA_ADDR) begin
					next_st.acc = st.data; // [RULE9]
				end
			end
			default: ;
		endcase
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (!RSTN_IN) begin
			st <= '{
				ext_en:  1'b0,
				bank_sel: RST_BANK,
				acc:     RST_ACC,
				status:  RST_STATUS,
				op:      OP_NONE,
				dest_f:  1'b0,
				ff_pend: 1'b0,
				data:    8'h00,
				rd:      1'b0,
				wr:      1'b0,
				ilo:     1'b0,
				addr:    12'h000,
				prdata:  32'h0000_0000
			};
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign INSTR_TAKE_OUT = (cif.phase == PH_Q1);
	assign DMEM_ADDR_OUT  = st.addr;
	assign DMEM_RD_OUT    = st.rd;
	assign DMEM_WR_OUT    = st.wr;
	assign DMEM_WDATA_OUT = st.data;
	assign DMEM_ILO_OUT   = st.ilo;
	assign ACC_OUT        = st.acc;
	assign STATUS_OUT     = st.status;
	assign PRDATA         = st.prdata;
	// answer follows setup by exactly one cycle, so ready never waits
	assign PREADY         = 1'b1;
	assign PSLVERR        = PSEL && PENABLE && !mapped;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RSTN_IN);

	property p_movb_read;
		(cif.phase == PH_Q1 && cif.op == OP_MOVB && !SKIP_IN && cif.bank_use
			&& {st.bank_sel, cif.f8} != ACC_DATA_ADDR)
			|=> DMEM_RD_OUT ##1 !DMEM_RD_OUT ##1 !DMEM_RD_OUT;
	endproperty
	a_movb_read: assert property (p_movb_read) else $error("move read missing"); // [RULE1]

	property p_movb_to_acc;
		(cif.phase == PH_Q1 && cif.op == OP_MOVB && !SKIP_IN && !cif.dest_f && !PSEL)
			|=> ##3 (ACC_OUT == DMEM_WDATA_OUT) && !DMEM_WR_OUT
			&& (!$past(DMEM_RD_OUT, 3) || ACC_OUT == $past(DMEM_RDATA_IN, 3));
	endproperty
	a_movb_to_acc: assert property (p_movb_to_acc) else $error("accumulator not loaded"); // [RULE2]

	property p_movb_to_file;
		(st.op == OP_MOVB && st.dest_f && !st.ilo && st.addr != ACC_DATA_ADDR
			&& cif.phase == PH_Q4) |-> DMEM_WR_OUT;
	endproperty
	a_movb_to_file: assert property (p_movb_to_file) else $error("file write missing"); // [RULE2]

	property p_bank_addr;
		(cif.phase == PH_Q1 && cif.op == OP_MOVB && !SKIP_IN && cif.bank_use && !PSEL)
			|=> DMEM_ADDR_OUT == {$past(st.bank_sel), $past(INSTR_IN[7:0])};
	endproperty
	a_bank_addr: assert property (p_bank_addr) else $error("bank address wrong"); // [RULE3]

	property p_ilo;
		(cif.phase == PH_Q1 && cif.op == OP_MOVB && !SKIP_IN && !cif.bank_use)
			|=> DMEM_ILO_OUT == ($past(st.ext_en) && $past(INSTR_IN[7:0]) <= ILO_MAX);
	endproperty
	a_ilo: assert property (p_ilo) else $error("indexed mode wrong"); // [RULE4]

	property p_flags;
		(cif.phase == PH_Q4 && st.op == OP_MOVB && !PSEL)
			|=> STATUS_OUT[ST_Z] == ($past(st.data) == 8'h00)
			&& STATUS_OUT[ST_N] == $past(st.data[7])
			&& STATUS_OUT[3] == $past(STATUS_OUT[3])
			&& STATUS_OUT[1:0] == $past(STATUS_OUT[1:0]);
	endproperty
	a_flags: assert property (p_flags) else $error("flag update wrong"); // [RULE5]

	property p_one_cycle;
		(cif.phase == PH_Q1 && cif.op == OP_MOVB && !SKIP_IN)
			|=> (st.op == OP_MOVB && !INSTR_TAKE_OUT && !st.ff_pend) [*3]
			##1 (st.op == OP_MOVB && INSTR_TAKE_OUT);
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("move not one cycle"); // [RULE6]

	property p_ff_second;
		(cif.phase == PH_Q1 && cif.op == OP_FF1 && !SKIP_IN)
			|=> st.ff_pend ##3 (cif.phase == PH_Q1 && cif.op == OP_FF2)
			##1 !DMEM_RD_OUT [*2]
			##1 (!DMEM_RD_OUT && DMEM_WR_OUT == (DMEM_ADDR_OUT != ACC_DATA_ADDR));
	endproperty
	a_ff_second: assert property (p_ff_second) else $error("second word wrong"); // [RULE11]

	property p_ff_flags;
		(cif.phase == PH_Q4 && (st.op == OP_FF1 || st.op == OP_FF2) && !PSEL)
			|=> $stable(STATUS_OUT);
	endproperty
	a_ff_flags: assert property (p_ff_flags) else $error("flags changed"); // [RULE12]

	property p_ff_src;
		(cif.phase == PH_Q1 && cif.op == OP_FF1 && !SKIP_IN && INSTR_IN[11:0] != ACC_DATA_ADDR)
			|=> DMEM_RD_OUT && DMEM_ADDR_OUT == $past(INSTR_IN[11:0]);
	endproperty
	a_ff_src: assert property (p_ff_src) else $error("source address wrong"); // [RULE8]
endmodule // bmd_top
`default_nettype wire

// [sim/bmd_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import bmd_pkg::*;
	localparam logic [11:0] ACC_A = 12'hFE8;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        skip = 1'b0;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [15:0] instr = 16'h0000;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rv;
	logic        take, rd, wr, ilo, pready, pslverr, ev, ilo_rd, d, a;
	logic [11:0] addr, a_rd, a_wr, s12, d12;
	logic [7:0]  wdata, acc, d_wr, e_acc, f;
	logic [7:0]  mem [4096];
	logic [4:0]  st, e_st;
	logic [3:0]  bank;
	logic        ext;
	int          failures = 0;
	int          cmp_count = 0;
	int          n_rd, n_wr;

	always #4 clk = ~clk;
	// data memory answers in the read cycle itself
	always @(posedge clk) if (wr === 1'b1) mem[addr] <= wdata;

	bmd_top #(.ACC_DATA_ADDR(ACC_A)) u_bmd_top (.SYS_CLK_IN(clk), .RSTN_IN(rstn),
		.INSTR_IN(instr), .SKIP_IN(skip), .INSTR_TAKE_OUT(take), .DMEM_ADDR_OUT(addr),
		.DMEM_RD_OUT(rd), .DMEM_RDATA_IN(mem[addr]), .DMEM_WR_OUT(wr),
		.DMEM_WDATA_OUT(wdata), .DMEM_ILO_OUT(ilo), .ACC_OUT(acc), .STATUS_OUT(st),
		.PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

	// ****************************************
	// checking and closing
	// ****************************************
	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: got %0h want %0h", $time, g, e);
		end
	endtask

	// ****************************************
	// apb master
	// ****************************************
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
		psel <= 1'b1;
		pwr <= w;
		paddr <= ad;
		pwdata <= dt;
		@(posedge clk);
		pen <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
			if (i == 49) begin
				failures++;
				summarize();
			end
		end
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		// idle edge so a following setup never lands in the release step
		@(posedge clk);
	endtask

	task automatic rreg(input logic [7:0] ad, input logic [31:0] x);
		apb(1'b0, ad, 32'h00000000);
		chk(rv, x);
		chk(32'(ev), 32'(ad > REG_STATE));
	endtask

	// ****************************************
	// instruction slots
	// ****************************************
	// apb traffic is three cycles, so realign to the next phase one
	task automatic sync();
		for (int i = 0; i < 8; i++) begin
			@(negedge clk);
			if (take === 1'b1) break;
		end
		chk(32'(take), 32'h1);
		if (take !== 1'b1) summarize();
		repeat (4) @(posedge clk);
	endtask

	task automatic exec(input logic [15:0] w, input logic s);
		n_rd = 0;
		n_wr = 0;
		instr <= w;
		skip <= s;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			if (i == 0) chk(32'(take), 32'h1);
			if (rd === 1'b1) begin
				n_rd++;
				a_rd = addr;
				ilo_rd = ilo;
			end
			if (wr === 1'b1) begin
				n_wr++;
				a_wr = addr;
				d_wr = wdata;
			end
			@(posedge clk);
			// cleared once, so the next call owns the final edge alone
			if (i == 0) begin
				instr <= 16'h0000;
				skip <= 1'b0;
			end
		end
	endtask

	task automatic chk_state();
		@(negedge clk);
		chk(32'(acc), 32'(e_acc));
		chk(32'(st), 32'(e_st));
		repeat (4) @(posedge clk);
	endtask

	task automatic sbm(input logic dd, input logic aa, input logic [7:0] ff);
		logic [11:0] ea;
		logic [7:0]  v;
		ea = aa ? {bank, ff} : ((ff < ACCESS_SPLIT) ? {ACCESS_LO_PAGE, ff} : {ACCESS_HI_PAGE, ff});
		v = mem[ea];
		exec({OPC_MOVB, dd, aa, ff}, 1'b0);
		chk(32'(n_rd), 32'h1);
		chk(32'(a_rd), 32'(ea));
		chk(32'(ilo_rd), 32'(!aa && ext && ff <= ILO_MAX));
		chk(32'(n_wr), 32'(dd));
		if (dd) chk(32'(d_wr), 32'(v));
		else e_acc = v;
		e_st[ST_N] = v[7];
		e_st[ST_Z] = (v == 8'h00);
		chk_state();
	endtask

	task automatic ffm(input logic [11:0] s, input logic [11:0] t, input logic sk);
		logic [7:0] v;
		v = (s == ACC_A) ? e_acc : mem[s];
		exec({OPC_FF1, s}, sk);
		chk(32'(n_rd), 32'(!sk && s != ACC_A));
		if (!sk && s != ACC_A) chk(32'(a_rd), 32'(s));
		exec({OPC_FF2, t}, 1'b0);
		chk(32'(n_rd), 32'h0);
		chk(32'(n_wr), 32'(!sk && t != ACC_A));
		if (!sk && t != ACC_A) chk(32'(a_wr), 32'(t));
		if (!sk && t != ACC_A) chk(32'(d_wr), 32'(v));
		if (!sk && t == ACC_A) e_acc = v;
		chk_state();
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(24396));
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 8'($urandom);
		end
		mem[0] = 8'h00;
		mem[1] = 8'h80;
		{e_acc, e_st, bank, ext} = '0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			if (i != 4) rreg(8'(i * 4), 32'h00000000);
		end
		// an unmapped write is refused and leaves the map alone
		apb(1'b1, 8'h18, 32'hFFFFFFFF);
		chk(32'(ev), 32'h1);
		bank = 4'($urandom);
		apb(1'b1, REG_BANK, {28'h0, bank});
		e_st = 5'($urandom);
		apb(1'b1, REG_STATUS, {27'h0, e_st});
		sync();
		sbm(1'b0, 1'b0, 8'h00);
		sbm(1'b1, 1'b0, 8'h01);
		sbm(1'b1, 1'b1, 8'h10);
		// a squashed move touches neither memory nor accumulator nor flags
		exec({OPC_MOVB, 2'b01, 8'h01}, 1'b1);
		chk(32'(n_rd + n_wr), 32'h0);
		chk_state();
		ext = 1'b1;
		apb(1'b1, REG_CTRL, 32'h00000001);
		sync();
		// setup lands in phase one after an idle slot
		rreg(REG_STATE, {23'h0, 1'b0, OP_NONE, PH_Q1});
		sync();
		sbm(1'b0, 1'b0, 8'h5F);
		sbm(1'b0, 1'b0, 8'h60);
		sbm(1'b0, 1'b1, 8'h20);
		for (int i = 0; i < 40; i++) begin
			{d, a, f} = 10'($urandom);
			if (f == ACC_A[7:0]) f = 8'hE9;
			sbm(d, a, f);
		end
		ffm(12'hFFF, 12'h000, 1'b0);
		ffm(ACC_A, 12'h123, 1'b0);
		ffm(12'h045, ACC_A, 1'b0);
		ffm(12'h200, 12'h300, 1'b1);
		for (int i = 0; i < 20; i++) begin
			s12 = 12'($urandom);
			d12 = 12'($urandom) & 12'hEFF;
			ffm(s12, d12, 1'($urandom));
		end
		rreg(REG_ACC, {24'h0, e_acc});
		rreg(REG_STATUS, {27'h0, e_st});
		summarize();
	end
endmodule // testbench
`default_nettype wire
